/* verification/link_master_control_quality_regs_tb.sv */
`timescale 1ns/100ps
module link_master_control_quality_regs_tb;
	reg clk_in = 0, srst_in = 1, wr_in = 0, rd_in = 0, ev_go_in = 0;
	reg pipe_reg_sel_in = 0, sync_in = 0, pos_received_in = 0;
	reg connection_established_in = 0, connection_lost_in = 0;
	reg monitor_start_in = 0;
	reg [5:0] addr_in = 0;
	reg [7:0] wdata_in = 0, pipe_status_in = 0, pipe_data_in = 0, r, d;
	reg [3:0] ev_sel_in = 0, s;
	wire [7:0] rdata_out, sync_divider_out;
	wire [3:0] quality_counter_out;
	wire [2:0] signal_strength_indication_in;
	wire safe_sync_last_wrong_in, safe_sync_early_wrong_in, safe_sync_ok_in;
	wire param_coding_err_in, process_coding_err_in, special_char_err_in;
	wire safe1_err_in, safe2_err_in, safe_crc_ok_in, strength_valid_in;
	wire protocol_reset_out, connection_restart_out, free_running_out;
	wire message_channel_reset_out, pipe_fifo_reset_out, sync_event_out;
	wire serial_pipe_enable_out, position_ready_out, line_oe_n_out;
	wire quality_low_warning_out, quality_reset_error_out, link_up_out;
	integer fails = 0, cmp_count = 0, i, q;
	lmq_link_master_control_quality_regs uut (.*);
	lmq_event_source u_src (.*);
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("unexpected %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [5:0] a, input [7:0] v);
		begin
			@(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, v};
			@(posedge clk_in) wr_in <= 0;
			repeat (2) @(posedge clk_in);
		end
	endtask
	task rd(input [5:0] a, output [7:0] v);
		begin
			@(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
			@(posedge clk_in) rd_in <= 0;
			#1 v = rdata_out;
		end
	endtask
	task ev(input [3:0] e);
		begin
			@(posedge clk_in) {ev_go_in, ev_sel_in} <= {1'b1, e};
			@(posedge clk_in) ev_go_in <= 0;
			repeat (4) @(posedge clk_in);
		end
	endtask
	task up;
		begin
			// Counter must leave zero before a connection can stand
			@(posedge clk_in) monitor_start_in <= 1;
			@(posedge clk_in) monitor_start_in <= 0;
			connection_established_in <= 1;
			@(posedge clk_in) connection_established_in <= 0;
			repeat (3) @(posedge clk_in);
		end
	endtask
	function integer nq(input integer v, input [3:0] e);
		integer t;
		begin
			t = v + (e == 2 || e == 8 ? 1 : e == 3 ? -1 : e == 4 || e == 5 ? -2
				: e == 0 || e == 9 ? -4 : e == 7 ? -8 : e == 10 ? 0 : -6);
			nq = t > 15 ? 15 : t < 0 ? 0 : t;
		end
	endfunction
	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		q = $urandom(32'h20a2);
		repeat (3) @(posedge clk_in);
		srst_in <= 0;
		rd(6'h00, r);
		chk("ctl", 8'h00, r);
		for (i = 0; i < 16; i = i + 1) begin
			d = $urandom & 8'h7f;
			wr(6'h00, d);
			rd(6'h00, r);
			chk("ctl", d, r);
			chk("oe_n", {7'h0, ~d[0]}, {7'h0, line_oe_n_out});
		end
		wr(6'h03, 8'hff);
		rd(6'h03, r);
		chk("qual", 8'h00, r);
		wr(6'h01, 8'h00);
		chk("free", 8'h01, {7'h0, free_running_out});
		pipe_status_in <= 8'h5a;
		pipe_reg_sel_in <= 1;
		for (i = 0; i < 2; i = i + 1) begin
			wr(6'h00, i << 2);
			rd(6'h2d, r);
			chk("pipe", i ? 8'h00 : 8'h5a, r);
			wr(6'h00, i << 3);
			@(posedge clk_in) pos_received_in <= 1;
			@(posedge clk_in) pos_received_in <= 0;
			#1 chk("position_ready_all", i, {7'h0, position_ready_out});
		end
		pipe_reg_sel_in <= 0;
		up;
		q = 8;
		for (i = 0; i < 48; i = i + 1) begin
			s = i < 8 ? 4'd2 : $urandom % 11;
			ev(s);
			q = nq(q, s);
			rd(6'h03, r);
			chk("qual", {q != 0, 3'h0, q[3:0]}, r);
			chk("warn", q < 14, {7'h0, quality_low_warning_out});
			chk("qcnt", {4'h0, q[3:0]},
				{4'h0, quality_counter_out});
			if (q == 0) begin
				chk("protocol_force_reset", 8'h01, {7'h0, protocol_reset_out});
				up;
				q = 8;
			end
		end
		wr(6'h00, 8'he0);
		chk("rst", 8'h07, {5'h0, protocol_reset_out, message_channel_reset_out,
			pipe_fifo_reset_out});
		@(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, 6'h00, 8'h00};
		@(posedge clk_in) wr_in <= 0;
		@(posedge clk_in) #1;
		chk("restart", 8'h01, {7'h0, connection_restart_out});
		wr(6'h01, 8'h04);
		for (i = 0; i < 2; i = i + 1) begin
			wr(6'h00, i << 1);
			@(posedge clk_in) sync_in <= 1;
			@(posedge clk_in) #1;
			chk("sync_r", i ? 0 : 1, {7'h0, sync_event_out});
			@(posedge clk_in) sync_in <= 0;
			@(posedge clk_in) #1;
			chk("sync_f", i, {7'h0, sync_event_out});
			@(posedge clk_in) pos_received_in <= 1;
			@(posedge clk_in) pos_received_in <= 0;
			#1 chk("position_ready_all_s", 8'h01, {7'h0, position_ready_out});
		end
		print_verdict;
	end
	initial begin
		#400000;
		fails = fails + 1;
		print_verdict;
	end
endmodule // link_master_control_quality_regs_tb

/* verification/lmq_event_source.sv */
`timescale 1ns/100ps
// Protocol engine stand-in: one event per request, never two at once
module lmq_event_source (
	input wire clk_in,
	input wire ev_go_in,
	input wire [3:0] ev_sel_in,
	output reg [2:0] signal_strength_indication_in = 0,
	output reg safe_sync_last_wrong_in = 0, safe_sync_early_wrong_in = 0,
	output reg safe_sync_ok_in = 0, param_coding_err_in = 0,
	output reg process_coding_err_in = 0, special_char_err_in = 0,
	output reg safe1_err_in = 0, safe2_err_in = 0, safe_crc_ok_in = 0,
	output reg strength_valid_in = 0
);
	wire [10:0] hot = ev_go_in ? 11'h400 >> ev_sel_in : 11'h000;
	always @(posedge clk_in) begin
		{safe_sync_last_wrong_in, safe_sync_early_wrong_in, safe_sync_ok_in,
			param_coding_err_in, process_coding_err_in, special_char_err_in,
			safe1_err_in, safe2_err_in, safe_crc_ok_in} <= hot[10:2];
		strength_valid_in <= hot[1] | hot[0];
		// Idle level is the weak value, so only the strobe may count it
		signal_strength_indication_in <= hot[0] ? 3'h6 : 3'h0;
	end
endmodule // lmq_event_source

/* verification/lmq_monitor.sv */
`timescale 1ns/100ps
module lmq_monitor (
	// Register bus
	input wire clk_in, srst_in, wr_in, rd_in, pipe_reg_sel_in,
	input wire [5:0] addr_in,
	input wire [7:0] wdata_in, rdata_out, sync_divider_out,
	// Controls
	input wire pos_received_in, position_ready_out, line_oe_n_out,
	input wire pipe_fifo_reset_out, serial_pipe_enable_out,
	input wire free_running_out, link_up_out, quality_reset_error_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	wire wc = wr_in && addr_in == 6'h00;
	wire ws = wr_in && addr_in == 6'h01;
	wire rq = rd_in && addr_in == 6'h03;
	oe_follow_a: assert property (
		wc |-> ##2 line_oe_n_out == !$past(wdata_in[0], 2)) else $error("oe");
	fifo_copy_a: assert property (
		wc |-> ##2 {pipe_fifo_reset_out, serial_pipe_enable_out} ==
		{$past(wdata_in[5], 2), $past(wdata_in[2], 2)}) else $error("ctl");
	div_copy_a: assert property (ws |-> ##2 sync_divider_out ==
		$past(wdata_in, 2) && free_running_out == ($past(wdata_in, 2) == 0))
		else $error("divider");
	rsvd_zero_a: assert property (
		rq |=> rdata_out[6:4] == 3'h0) else $error("reserved");
	link_bit_a: assert property (
		rq |=> rdata_out[7] == link_up_out) else $error("link");
	err_link_a: assert property (
		quality_reset_error_out |=> !link_up_out) else $error("err link");
	wo_zero_a: assert property (
		rd_in && addr_in == 6'h01 |=> rdata_out == 8'h00) else $error("wo");
	pipe_zero_a: assert property (
		rd_in && pipe_reg_sel_in && serial_pipe_enable_out |=> rdata_out == 0)
		else $error("pipe");
	pos_cause_a: assert property (
		position_ready_out |-> $past(pos_received_in)) else $error("pos");
	cover property (wc && wdata_in[0]);
	cover property (position_ready_out);
	cover property ($fell(link_up_out));
	cover property (quality_reset_error_out);
endmodule // lmq_monitor
bind lmq_link_master_control_quality_regs lmq_monitor u_mon (.*);

/* verilog/lmq_defines.vh */
`ifndef LMQ_DEFINES_VH
`define LMQ_DEFINES_VH
// Register offsets on the drive interface
`define LMQ_ADDR_SYSTEM_CONTROL 6'h00
`define LMQ_ADDR_SYNC_CONTROL 6'h01
`define LMQ_ADDR_LINK_QUALITY 6'h03
// Reset values
`define LMQ_RST_SYSTEM_CONTROL 8'h00
`define LMQ_RST_SYNC_CONTROL 8'h01
// system_control bit positions
`define LMQ_BIT_PROTOCOL_FORCE_RESET 7
`define LMQ_BIT_MESSAGE_CHANNEL_RESET 6
`define LMQ_BIT_PIPE_FIFO_RESET 5
`define LMQ_BIT_READBACK_TEST 4
`define LMQ_BIT_POSITION_READY_ALL 3
`define LMQ_BIT_SERIAL_PIPE_ENABLE 2
`define LMQ_BIT_SYNC_EDGE_SELECT 1
`define LMQ_BIT_LINE_DRIVE_ON 0
// link_quality fields
`define LMQ_BIT_CONNECTION_UP 7
// Quality counter figures
`define LMQ_QUAL_START 4'h8
`define LMQ_QUAL_MAX 5'h0f
`define LMQ_QUAL_WARN 4'he
`define LMQ_DEC_SAFE_SYNC_LAST 5'h04
`define LMQ_DEC_SAFE_SYNC_EARLY 5'h06
`define LMQ_DEC_WEAK_SIGNAL 5'h04
`define LMQ_DEC_PARAM_CODING 5'h01
`define LMQ_DEC_PROCESS_CODING 5'h02
`define LMQ_DEC_SPECIAL_CHAR 5'h02
`define LMQ_DEC_SAFE1_ERROR 5'h06
`define LMQ_DEC_SAFE2_ERROR 5'h08
`endif

/* verilog/lmq_link_master_control_quality_regs.v */
`timescale 1ns/100ps
// Overview of operation
// - Control bits change only by host writes or master reset.
// - Bit 7 holds protocol in reset; clearing it restarts connection.
// - Bit 6 resets message channel, discarding messages in progress.
// - Bit 5 holds pipeline FIFO in reset, empty and unreadable.
// - Bit 4 is a readback test bit with no other effect.
// - Bit 3: position-ready on every position, else only after sync.
// - Bit 2 routes pipe to serial port; pipe registers then read zero.
// - Bit 1 picks sync trailing edge when one, leading when zero.
// - Bit 0 enables cable drivers; zero leaves them high impedance.
// - Safe sync: last byte wrong -4, early byte wrong -6, correct +1.
// - Coding errors: parameter/hub -1, process data -2, special char -2.
// - Safe channel 1 error -6, channel 2 error -8, good checksum +1.
// - Quality counter loads 8 when monitoring starts.
// - Quality counter never exceeds 15.
// - Counter below 14 raises quality_low_warning.
// - Counter at zero forces protocol reset; reports it only if connection_up is still set.
// - Quality register ignores writes; bits 3..0 hold the counter.
// - Bit 7 shows connection_up, also driven on the link output.
`include "lmq_defines.vh"

module lmq_link_master_control_quality_regs (
	// Clock and reset
	input wire clk_in,
	input wire srst_in,
	// Drive interface register access
	input wire [5:0] addr_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	// Pipe register contents from the pipe logic
	input wire [7:0] pipe_status_in,
	input wire [7:0] pipe_data_in,
	input wire pipe_reg_sel_in,
	// Sync input and position receipt
	input wire sync_in,
	input wire pos_received_in,
	// Protocol quality events, one-cycle pulses
	input wire connection_established_in,
	input wire connection_lost_in,
	input wire monitor_start_in,
	input wire safe_sync_last_wrong_in,
	input wire safe_sync_early_wrong_in,
	input wire safe_sync_ok_in,
	input wire param_coding_err_in,
	input wire process_coding_err_in,
	input wire special_char_err_in,
	input wire safe1_err_in,
	input wire safe2_err_in,
	input wire safe_crc_ok_in,
	input wire [2:0] signal_strength_indication_in,
	input wire strength_valid_in,
	// Control outputs to the channel logic
	output reg protocol_reset_out,
	output reg connection_restart_out,
	output reg message_channel_reset_out,
	output reg pipe_fifo_reset_out,
	output reg serial_pipe_enable_out,
	output reg [7:0] sync_divider_out,
	output reg free_running_out,
	output reg sync_event_out,
	output reg position_ready_out,
	// Line driver enable, low while driving
	output reg line_oe_n_out,
	// Status
	output reg [3:0] quality_counter_out,
	output reg quality_low_warning_out,
	output reg quality_reset_error_out,
	output reg link_up_out
);

	reg [7:0] system_control;
	reg [7:0] sync_control;
	reg [3:0] quality_counter;
	reg connection_up;
	reg sync_prev;
	reg sync_armed;
	reg protocol_force_reset_prev;
	reg qual_zero_prev;
	reg [4:0] next_quality;
	reg [5:0] dec_sum;
	reg [1:0] inc_sum;
	wire [7:0] pen_hit;
	wire [39:0] pen_weight;
	wire [5:0] pen_acc [0:8];
	reg [7:0] next_rdata;
	wire sync_rise;
	wire sync_fall;
	wire sync_edge;
	wire qual_zero;
	wire force_reset;

	assign sync_rise = sync_in & ~sync_prev;
	assign sync_fall = ~sync_in & sync_prev;
	assign sync_edge = system_control[`LMQ_BIT_SYNC_EDGE_SELECT] ?
		sync_fall : sync_rise;
	// A zero counter holds the protocol in reset until the next start load
	assign qual_zero = (quality_counter == 4'h0);
	assign force_reset = system_control[`LMQ_BIT_PROTOCOL_FORCE_RESET] |
		qual_zero;

	// Only host writes and reset touch the control bits
	always @(posedge clk_in) begin
		if (srst_in) begin
			system_control <= `LMQ_RST_SYSTEM_CONTROL;
		end else if (wr_in && addr_in == `LMQ_ADDR_SYSTEM_CONTROL) begin
			system_control <= wdata_in;
		end
	end

	// No read path here, so the host must keep its own copy
	always @(posedge clk_in) begin
		if (srst_in) begin
			sync_control <= `LMQ_RST_SYNC_CONTROL;
		end else if (wr_in && addr_in == `LMQ_ADDR_SYNC_CONTROL) begin
			sync_control <= wdata_in;
		end
	end

	// Penalty events, one bit each, weak signal at the bottom
	localparam PEN_COUNT = 8;
	assign pen_hit = {
		safe_sync_last_wrong_in,
		safe_sync_early_wrong_in,
		param_coding_err_in,
		process_coding_err_in,
		special_char_err_in,
		safe1_err_in,
		safe2_err_in,
		strength_valid_in &
			(signal_strength_indication_in == 3'h0)
	};
	// Weights line up with pen_hit, five bits per event
	assign pen_weight = {
		`LMQ_DEC_SAFE_SYNC_LAST,
		`LMQ_DEC_SAFE_SYNC_EARLY,
		`LMQ_DEC_PARAM_CODING,
		`LMQ_DEC_PROCESS_CODING,
		`LMQ_DEC_SPECIAL_CHAR,
		`LMQ_DEC_SAFE1_ERROR,
		`LMQ_DEC_SAFE2_ERROR,
		`LMQ_DEC_WEAK_SIGNAL
	};

	// Running penalty sum; all eight at once (33) still fit six bits
	assign pen_acc[0] = 6'h00;
	genvar gi;
	generate
		for (gi = 0; gi < PEN_COUNT; gi = gi + 1) begin : g_pen
			assign pen_acc[gi + 1] = pen_acc[gi] +
				(pen_hit[gi] ? {1'b0, pen_weight[gi * 5 +: 5]} : 6'h00);
		end
	endgenerate

	// Two reward sources at most, so two bits hold their sum
	always @* begin
		dec_sum = pen_acc[PEN_COUNT];
		inc_sum = {1'b0, safe_sync_ok_in} +
			{1'b0, safe_crc_ok_in};
	end

	// Rewards clamp at the top first, then penalties floor at zero
	always @* begin
		next_quality = {1'b0, quality_counter} + {3'h0, inc_sum};
		if (next_quality > `LMQ_QUAL_MAX) begin
			next_quality = `LMQ_QUAL_MAX;
		end
		if (dec_sum >= {1'b0, next_quality}) begin
			next_quality = 5'h00;
		end else begin
			next_quality = next_quality - dec_sum[4:0];
		end
	end

	// Start load wins; the counter only moves while a connection stands
	always @(posedge clk_in) begin
		if (srst_in) begin
			quality_counter <= 4'h0;
		end else if (monitor_start_in) begin
			quality_counter <= `LMQ_QUAL_START;
		end else if (connection_up) begin
			quality_counter <= next_quality[3:0];
		end
	end

	// Loss or an exhausted counter beats a new connection in one cycle
	always @(posedge clk_in) begin
		if (srst_in) begin
			connection_up <= 1'b0;
		end else if (force_reset || connection_lost_in) begin
			connection_up <= 1'b0;
		end else if (connection_established_in) begin
			connection_up <= 1'b1;
		end
	end

	// Edge detector rests low, the idle level of sync_in, so no false edge
	always @(posedge clk_in) begin
		if (srst_in) begin
			sync_prev <= 1'b0;
			sync_event_out <= 1'b0;
		end else begin
			sync_prev <= sync_in;
			sync_event_out <= sync_edge & ~free_running_out;
		end
	end

	// A selected sync edge arms the next position receipt
	always @(posedge clk_in) begin
		if (srst_in) begin
			sync_armed <= 1'b0;
			position_ready_out <= 1'b0;
		end else begin
			position_ready_out <= pos_received_in &
				(system_control[`LMQ_BIT_POSITION_READY_ALL] |
				sync_armed);
			// An edge beside a receipt keeps the arm for the next one
			if (sync_edge) begin
				sync_armed <= 1'b1;
			end else if (pos_received_in) begin
				sync_armed <= 1'b0;
			end
		end
	end

	// Protocol reset from the host force bit or an exhausted counter
	always @(posedge clk_in) begin
		if (srst_in) begin
			protocol_force_reset_prev <= 1'b0;
			protocol_reset_out <= 1'b1;
			connection_restart_out <= 1'b0;
		end else begin
			protocol_force_reset_prev <= system_control[`LMQ_BIT_PROTOCOL_FORCE_RESET];
			protocol_reset_out <= force_reset;
			// Falling force bit gives a single restart pulse
			connection_restart_out <= protocol_force_reset_prev &
				~system_control[`LMQ_BIT_PROTOCOL_FORCE_RESET];
		end
	end

	// Channel resets and pipe routing are registered copies of the bits
	always @(posedge clk_in) begin
		if (srst_in) begin
			message_channel_reset_out <= 1'b0;
			pipe_fifo_reset_out <= 1'b0;
			serial_pipe_enable_out <= 1'b0;
		end else begin
			message_channel_reset_out <=
				system_control[`LMQ_BIT_MESSAGE_CHANNEL_RESET];
			pipe_fifo_reset_out <=
				system_control[`LMQ_BIT_PIPE_FIFO_RESET];
			serial_pipe_enable_out <=
				system_control[`LMQ_BIT_SERIAL_PIPE_ENABLE];
		end
	end

	// Divider value and the free-running flag it implies
	always @(posedge clk_in) begin
		if (srst_in) begin
			sync_divider_out <= `LMQ_RST_SYNC_CONTROL;
			free_running_out <= 1'b0;
		end else begin
			sync_divider_out <= sync_control;
			free_running_out <= (sync_control == 8'h00);
		end
	end

	// Cable drivers stay off through reset
	always @(posedge clk_in) begin
		if (srst_in) begin
			line_oe_n_out <= 1'b1;
		end else begin
			line_oe_n_out <=
				~system_control[`LMQ_BIT_LINE_DRIVE_ON];
		end
	end

	// Status copies; the reset error pulses once per drop to zero
	always @(posedge clk_in) begin
		if (srst_in) begin
			qual_zero_prev <= 1'b0;
			quality_counter_out <= 4'h0;
			quality_low_warning_out <= 1'b0;
			quality_reset_error_out <= 1'b0;
			link_up_out <= 1'b0;
		end else begin
			qual_zero_prev <= qual_zero & connection_up;
			quality_counter_out <= quality_counter;
			quality_low_warning_out <=
				(quality_counter < `LMQ_QUAL_WARN);
			quality_reset_error_out <= qual_zero & connection_up &
				~qual_zero_prev;
			link_up_out <= connection_up;
		end
	end

	// Read data; sync_control is write-only and reads zero
	always @* begin
		next_rdata = 8'h00;
		case (addr_in)
		`LMQ_ADDR_SYSTEM_CONTROL: begin
			next_rdata = system_control;
		end
		`LMQ_ADDR_SYNC_CONTROL: begin
			next_rdata = 8'h00;
		end
		`LMQ_ADDR_LINK_QUALITY: begin
			next_rdata = {connection_up, 3'h0,
				quality_counter};
		end
		default: begin
			// Outside logic decodes the pipe offsets
			if (pipe_reg_sel_in &&
				!system_control[`LMQ_BIT_SERIAL_PIPE_ENABLE])
				next_rdata = pipe_status_in | pipe_data_in;
		end
		endcase
	end

	// Read data holds between reads
	always @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			rdata_out <= next_rdata;
		end
	end

endmodule // lmq_link_master_control_quality_regs
